// ===== sim/channel_indexed_config_regs_tb.sv
`default_nettype none
module channel_indexed_config_regs_tb import cfg_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************
  // bench signals and dut
  // ****************************
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  localparam logic [7:0] GR = 8'h47; // arbitrary value
  logic clk, nrst, sclk, csLow, mosi, dOut, dOeN, lsbFirst, line;
  logic [7:0] powerMode, clockCtrl, clockDivide, enhanceCtrl;
  logic [7:0] transferCtrl, q, v;
  logic [7:0] lv [NUM_CHAN];
  logic [8*NUM_CHAN-1:0] testMode;
  logic [15:0] gl [5];
  int errCount, totalChecks;

  assign line = dOeN ? mosi : dOut;
  channel_indexed_config_regs #(.PART_ID(ID), .GRADE_ID(GR)) dut (
    .clk(clk), .nrst(nrst), .serialClk(sclk), .chip_select_low(csLow),
    .dataIn(line), .dataOut(dOut), .dataOeN(dOeN),
    .powerMode(powerMode), .clockCtrl(clockCtrl),
    .clockDivide(clockDivide), .enhanceCtrl(enhanceCtrl),
    .transferCtrl(transferCtrl), .testMode(testMode),
    .lsbFirst(lsbFirst));
  serial_host host (.clk(clk), .line(line), .sclk(sclk),
    .csLow(csLow), .mosi(mosi));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************
  // tasks and expectations
  // ****************************
  task automatic check(input logic [7:0] seen, exp, input string w);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error %0t %s: got %h want %h", $time, w, seen, exp);
    end
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.frame(1'b0, a, d, q);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e,
      input string w);
    host.frame(1'b1, a, 8'h00, q);
    check(q, e, w);
  endtask
  task automatic doReset();
    @(negedge clk);
    nrst = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  function automatic logic [7:0] mask(input logic [15:0] a);
    case (a)
      ADDR_POWER: return POWER_MASK;
      ADDR_CLOCK: return CLOCK_MASK;
      ADDR_CLKDIV: return CLKDIV_MASK;
      ADDR_ENHANCE: return ENHANCE_MASK;
      default: return TRANSFER_MASK;
    endcase
  endfunction
  function automatic logic [7:0] port(input logic [15:0] a);
    case (a)
      ADDR_POWER: return powerMode;
      ADDR_CLOCK: return clockCtrl;
      ADDR_CLKDIV: return clockDivide;
      ADDR_ENHANCE: return enhanceCtrl;
      default: return transferCtrl;
    endcase
  endfunction
  // byte as the host must send it for lsb-first order
  function automatic logic [7:0] rev(input logic [7:0] x);
    for (int i = 0; i < 8; i++)
      rev[i] = x[7-i];
  endfunction
  task automatic defaults(input string w);
    check(powerMode, POWER_RESET, w);
    check(clockCtrl, CLOCK_RESET, w);
    check(clockDivide, CLKDIV_RESET, w);
    check(enhanceCtrl, ENHANCE_RESET, w);
    check(transferCtrl, TRANSFER_RESET, w);
    for (int k = 0; k < NUM_CHAN; k++)
      check(testMode[8*k +: 8], TEST_RESET, w);
    check({7'h0, lsbFirst}, 8'h00, w);
    rdc(ADDR_SETUP, SETUP_RESET, w);
    rdc(ADDR_CHAN_SEL, CHAN_SEL_RESET, w);
  endtask
  // ****************************
  // main sequence
  // ****************************
  initial begin
    errCount = 0;
    totalChecks = 0;
    nrst = 1'b0;
    gl = '{ADDR_POWER, ADDR_CLOCK, ADDR_CLKDIV, ADDR_ENHANCE,
      ADDR_TRANSFER};
    void'($urandom(32'haf580a68));
    doReset();
    defaults("reset");
    rdc(ADDR_PART_ID, ID, "id");
    rdc(ADDR_GRADE, GR & GRADE_MASK, "grade");
    wr(ADDR_PART_ID, 8'ha5);
    rdc(ADDR_PART_ID, ID, "id write");
    $display("test defaults done");
    // one channel only, globals must not care
    wr(ADDR_CHAN_SEL, 8'h02);
    for (int k = 0; k < 5; k++) begin
      v = 8'($urandom()) & mask(gl[k]);
      wr(gl[k], v);
      check(port(gl[k]), v, "global port");
      rdc(gl[k], v, "global read");
    end
    $display("test globals done");
    wr(ADDR_CHAN_SEL, 8'h3f);
    v = 8'($urandom()) & TEST_MASK;
    wr(ADDR_TEST, v);
    for (int k = 0; k < NUM_CHAN; k++)
      check(testMode[8*k +: 8], v, "broadcast");
    for (int k = 0; k < NUM_CHAN; k++) begin
      lv[k] = (8'($urandom()) & 8'hd0) | 8'(k + 1);
      wr(ADDR_CHAN_SEL, 8'(1 << k));
      wr(ADDR_TEST, lv[k]);
    end
    for (int k = 0; k < NUM_CHAN; k++)
      check(testMode[8*k +: 8], lv[k], "copy");
    wr(ADDR_CHAN_SEL, 8'h3f);
    rdc(ADDR_TEST, lv[0], "all read");
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CHAN_SEL, 8'(1 << k));
      rdc(ADDR_TEST, lv[k], "local read");
    end
    $display("test locals done");
    wr(ADDR_SETUP, 8'h3c);
    defaults("soft reset");
    $display("test soft reset done");
    wr(ADDR_SETUP, 8'h5a);
    check({7'h0, lsbFirst}, 8'h01, "lsb first");
    // data bytes now travel lsb first in both directions
    v = 8'($urandom()) & CLKDIV_MASK;
    wr(ADDR_CLKDIV, rev(v));
    check(clockDivide, v, "lsb write");
    rdc(ADDR_CLKDIV, rev(v), "lsb read");
    doReset();
    defaults("second reset");
    $display("test order done");
    endSim();
  end

  // about 50 frames of 10 us, so 2 ms is ample
  initial begin
    #2ms;
    errCount++;
    endSim();
  end
endmodule
`default_nettype wire

// ===== sim/serial_host.sv
`default_nettype none
// ****************************
// three-wire host, one byte a frame
// ****************************
module serial_host (
  input wire logic clk, // core clock
  input wire logic line, // resolved data line
  output logic sclk, // serial clock
  output logic csLow, // frame select, low active
  output logic mosi // host drive of data line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b0;
    csLow = 1'b1;
    mosi = 1'b0;
  end

  // 8 clk a phase, above the 4 clk the sync needs
  task automatic half();
    repeat (8) @(negedge clk);
  endtask

  task automatic frame(input logic rd, input logic [15:0] a,
      input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] sh;
    sh = {rd, 2'b00, a[12:0], wd};
    q = 8'h00;
    csLow = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // released line toggles so no stale bit is read
      mosi = (rd && i < 8) ? ~mosi : sh[i];
      half();
      sclk = 1'b1;
      if (i < 8)
        q[i] = line;
      half();
      sclk = 1'b0;
    end
    half();
    csLow = 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

// ===== src/cfg_regs_pkg.sv
`default_nettype none
package cfg_regs_pkg;
  localparam logic [15:0] ADDR_SETUP = 16'h0000;
  localparam logic [15:0] ADDR_PART_ID = 16'h0001;
  localparam logic [15:0] ADDR_GRADE = 16'h0002;
  localparam logic [15:0] ADDR_CHAN_SEL = 16'h0005;
  localparam logic [15:0] ADDR_TRANSFER = 16'h00ff;
  localparam logic [15:0] ADDR_GLOBAL_LO = 16'h0008;
  localparam logic [15:0] ADDR_GLOBAL_HI = 16'h0109;
  localparam logic [15:0] ADDR_POWER = 16'h0008;
  localparam logic [15:0] ADDR_CLOCK = 16'h0009;
  localparam logic [15:0] ADDR_CLKDIV = 16'h000b;
  localparam logic [15:0] ADDR_ENHANCE = 16'h000c;
  localparam logic [15:0] ADDR_TEST = 16'h000d;
  localparam logic [7:0] GRADE_MASK = 8'h70;
  localparam logic [7:0] SETUP_RESET = 8'h18;
  localparam logic [7:0] SETUP_FIXED_MASK = 8'h99;
  localparam logic [7:0] SETUP_FIXED_VAL = 8'h18;
  localparam int SETUP_SRST_HI = 5;
  localparam int SETUP_SRST_LO = 2;
  localparam int SETUP_LSB_HI = 6;
  localparam int SETUP_LSB_LO = 1;
  localparam logic [7:0] CHAN_SEL_RESET = 8'h3f;
  localparam logic [7:0] CHAN_SEL_MASK = 8'h3f;
  localparam logic [5:0] CHAN_ALL = 6'h3f;
  localparam logic [7:0] TRANSFER_RESET = 8'h00;
  localparam logic [7:0] TRANSFER_MASK = 8'h01;
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam logic [7:0] POWER_MASK = 8'h23;
  localparam logic [7:0] CLOCK_RESET = 8'h01;
  localparam logic [7:0] CLOCK_MASK = 8'h01;
  localparam logic [7:0] CLKDIV_RESET = 8'h00;
  localparam logic [7:0] CLKDIV_MASK = 8'h07;
  localparam logic [7:0] ENHANCE_RESET = 8'h00;
  localparam logic [7:0] ENHANCE_MASK = 8'h04;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [7:0] TEST_MASK = 8'hdf;
  localparam int NUM_CHAN = 6;
  localparam int INSTR_BITS = 16;
  localparam int WORD_BITS = 8;
  localparam logic [4:0] INSTR_LAST = 5'd15;
  localparam logic [2:0] WORD_LAST = 3'd7;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic we;
  } reg_wr_s;
endpackage
`default_nettype wire

// ===== src/channel_indexed_config_regs.sv
// How it works
// [R1] decode chip config, index/transfer and global regions up to 0x109
// [R2] host writes zero into open bits of partly defined registers
// [R3] host never writes wholly open or unlisted addresses
// [R4] reset loads every register with its default
// [R5] local registers copied per data and clock channel, chosen by index bits
// [R6] all index bits set: local write updates every copy
// [R7] host selects exactly one data channel before local read
// [R8] several selected on read: lowest data channel copy returned
// [R9] global registers ignore the channel index
// [R10] channel index resets to 0x3f
// [R11] setup register fixed bits, mirrored nibbles, default 0x18
// [R12] soft reset bit restores defaults and clears itself
// [R13] access only through three-wire port with 16-bit addresses; code takes only 13 address bits from the instruction
// [R14] read-only part identifier, writes ignored
// [R15] 16-bit instruction, first bit read; data line turns for reads
// [R16] 8-bit words, msb first unless lsb-first selected
// [R17] streaming with select low; select may pause high between bytes; code ends the frame when select goes high
// [R18] open bits read zero, read-only writes ignored
`default_nettype none
module channel_indexed_config_regs
  import cfg_regs_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] GRADE_ID = 8'h20 // arbitrary value
) (
  input wire logic clk, // core clock
  input wire logic nrst, // async reset, low active
  input wire logic serialClk, // serial shift clock pin
  input wire logic chip_select_low, // frame select pin, low active
  input wire logic dataIn, // data line input
  output logic dataOut, // data line output
  output logic dataOeN, // data line enable, low drives
  output logic [7:0] powerMode, // global power register
  output logic [7:0] clockCtrl, // global clock register
  output logic [7:0] clockDivide, // global divide register
  output logic [7:0] enhanceCtrl, // global enhance register
  output logic [7:0] transferCtrl, // transfer register
  output logic [8*NUM_CHAN-1:0] testMode, // local test mode per channel
  output logic lsbFirst // bit order in use
);
  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  logic rq1, rstN;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rq1 <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rq1 <= 1'b1;
      rstN <= rq1;
    end
  end
  logic sclkRise, sclkFall, csLvl, csAssert, csRelease, sdiLvl;
  // cs is synced relative to its idle high so its level means selected
  sync_3ff uSclk (.clk(clk), .rstN(rstN), .pin(serialClk), .resetVal(1'b0),
    .level(), .rise(sclkRise), .fall(sclkFall));
  sync_3ff uCs (.clk(clk), .rstN(rstN), .pin(chip_select_low),
    .resetVal(1'b1), .level(csLvl), .rise(csAssert), .fall(csRelease));
  sync_3ff uSdi (.clk(clk), .rstN(rstN), .pin(dataIn), .resetVal(1'b0),
    .level(sdiLvl), .rise(), .fall());
  // ****************************************
  // serial frame engine
  // ****************************************
  typedef enum logic [1:0] {IDLE, INSTR, DATA} phase_e;
  phase_e phase;
  logic [4:0] bitCnt;
  logic [15:0] shiftReg;
  logic isRead, driving;
  logic [15:0] curAddr;
  reg_wr_s wr;
  wire selected = csLvl;
  wire sampleBit = selected && sclkRise && phase != IDLE;
  wire [15:0] shiftNext = {shiftReg[14:0], sdiLvl};
  wire wordDone = sampleBit && phase == DATA && bitCnt[2:0] == WORD_LAST;
  wire instrDone = sampleBit && phase == INSTR && bitCnt == INSTR_LAST;
  // lsb-first reverses each received byte before use [R16]
  wire [7:0] rxMsb = shiftNext[7:0];
  wire [7:0] rxByte = lsbFirst ? {<<{rxMsb}} : rxMsb; // [R16]
  wire [7:0] readData;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      phase <= IDLE;
      bitCnt <= 5'd0;
      shiftReg <= 16'h0000;
      isRead <= 1'b0;
      curAddr <= 16'h0000;
      driving <= 1'b0;
    end else if (csAssert && phase == IDLE) begin
      phase <= INSTR; // [R15]
      bitCnt <= 5'd0;
    end else if (csRelease) begin
      // limitation: deselect ends the frame, next select wants an instruction
      phase <= IDLE; // [R15]
      driving <= 1'b0;
    end else if (sampleBit) begin
      shiftReg <= shiftNext;
      bitCnt <= (phase == DATA) ? {2'b00, bitCnt[2:0] + 3'd1}
                                : bitCnt + 5'd1;
      if (instrDone) begin
        phase <= DATA; // [R15]
        isRead <= shiftNext[15]; // [R15]
        curAddr <= {3'b000, shiftNext[12:0]}; // [R13]
        driving <= shiftNext[15]; // [R15]
        bitCnt <= 5'd0;
      end else if (wordDone) begin
        // select held low streams; bit order sets address direction [R17]
        curAddr <= lsbFirst ? curAddr + 16'd1 : curAddr - 16'd1;
      end
    end
  end
  // shifting out on falling serial clock edges [R15]
  logic [2:0] outIdx;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      outIdx <= 3'd0;
      dataOut <= 1'b0;
    end else if (phase == DATA && isRead && sclkFall) begin
      outIdx <= outIdx + 3'd1;
      dataOut <= lsbFirst ? readData[outIdx] : readData[3'd7 - outIdx];
    end else if (phase != DATA) begin
      outIdx <= 3'd0;
      dataOut <= 1'b0;
    end
  end
  assign dataOeN = !(driving && selected && phase == DATA); // [R15]
  assign wr = {curAddr, rxByte, wordDone && !isRead};
  // ****************************************
  // register bank
  // ****************************************
  logic [7:0] setup, chanSel;
  logic [7:0] testCopy [NUM_CHAN];
  wire inRange = wr.addr <= ADDR_GLOBAL_HI; // [R1]
  wire wSetup = wr.we && wr.addr == ADDR_SETUP;
  wire wChan = wr.we && wr.addr == ADDR_CHAN_SEL;
  wire wXfer = wr.we && wr.addr == ADDR_TRANSFER;
  wire wPow = wr.we && wr.addr == ADDR_POWER && inRange;
  wire wClk = wr.we && wr.addr == ADDR_CLOCK;
  wire wDiv = wr.we && wr.addr == ADDR_CLKDIV;
  wire wEnh = wr.we && wr.addr == ADDR_ENHANCE;
  wire wTest = wr.we && wr.addr == ADDR_TEST;
  // soft reset request from either mirrored bit position [R12]
  wire softRst = wSetup && (wr.data[SETUP_SRST_HI] || wr.data[SETUP_SRST_LO]);
  wire [7:0] setupWr = (wr.data & ~SETUP_FIXED_MASK) | SETUP_FIXED_VAL;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      setup <= SETUP_RESET; // [R4] [R11]
      chanSel <= CHAN_SEL_RESET; // [R10]
      transferCtrl <= TRANSFER_RESET;
      powerMode <= POWER_RESET;
      clockCtrl <= CLOCK_RESET;
      clockDivide <= CLKDIV_RESET;
      enhanceCtrl <= ENHANCE_RESET;
    end else if (softRst) begin
      // self-clearing: soft reset bits never stored [R12]
      setup <= SETUP_RESET; // [R12]
      chanSel <= CHAN_SEL_RESET;
      transferCtrl <= TRANSFER_RESET;
      powerMode <= POWER_RESET;
      clockCtrl <= CLOCK_RESET;
      clockDivide <= CLKDIV_RESET;
      enhanceCtrl <= ENHANCE_RESET;
    end else begin
      if (wSetup) begin
        // mirror bit order so either orientation lands the same [R11]
        setup <= {1'b0, setupWr[SETUP_LSB_HI] | setupWr[SETUP_LSB_LO],
          2'b01, 2'b10, setupWr[SETUP_LSB_HI] | setupWr[SETUP_LSB_LO],
          1'b0}; // [R11]
      end
      if (wChan) chanSel <= wr.data & CHAN_SEL_MASK; // [R18]
      if (wXfer) transferCtrl <= wr.data & TRANSFER_MASK;
      if (wPow) powerMode <= wr.data & POWER_MASK; // [R9]
      if (wClk) clockCtrl <= wr.data & CLOCK_MASK; // [R9]
      if (wDiv) clockDivide <= wr.data & CLKDIV_MASK;
      if (wEnh) enhanceCtrl <= wr.data & ENHANCE_MASK;
    end
  end
  assign lsbFirst = setup[SETUP_LSB_HI]; // [R16]
  // per-channel copies of the local register [R5]
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : gChan
      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          testCopy[ch] <= TEST_RESET; // [R4]
        end else if (softRst) begin
          testCopy[ch] <= TEST_RESET;
        end else if (wTest && chanSel[ch]) begin
          testCopy[ch] <= wr.data & TEST_MASK; // [R5] [R6]
        end
      end
      assign testMode[8*ch +: 8] = testCopy[ch];
    end
  endgenerate
  // lowest selected data channel wins on read [R8]
  wire [7:0] localRd = chanSel[0] ? testCopy[0] :
                       chanSel[1] ? testCopy[1] :
                       chanSel[2] ? testCopy[2] :
                       chanSel[3] ? testCopy[3] : 8'h00; // [R8]
  // read mux on current address; unmapped reads as zero [R18]
  assign readData =
    (curAddr == ADDR_SETUP) ? setup :
    (curAddr == ADDR_PART_ID) ? PART_ID : // [R14]
    (curAddr == ADDR_GRADE) ? (GRADE_ID & GRADE_MASK) : // [R14] [R18]
    (curAddr == ADDR_CHAN_SEL) ? chanSel :
    (curAddr == ADDR_TRANSFER) ? transferCtrl :
    (curAddr == ADDR_POWER) ? powerMode :
    (curAddr == ADDR_CLOCK) ? clockCtrl :
    (curAddr == ADDR_CLKDIV) ? clockDivide :
    (curAddr == ADDR_ENHANCE) ? enhanceCtrl :
    (curAddr == ADDR_TEST) ? localRd : 8'h00; // [R1] [R18]
  // ****************************************
  // checks
  // ****************************************
  a_index_reset: assert property (@(posedge clk) $rose(rstN) |->
    chanSel == CHAN_SEL_RESET) else $error("index reset wrong"); // [R10]
  a_setup_fixed: assert property (@(posedge clk) disable iff (!rstN)
    (setup & SETUP_FIXED_MASK) == SETUP_FIXED_VAL)
    else $error("setup fixed bits"); // [R11]
  a_soft_clear: assert property (@(posedge clk) disable iff (!rstN)
    softRst |=> setup == SETUP_RESET && chanSel == CHAN_SEL_RESET)
    else $error("soft reset incomplete"); // [R12]
  a_broadcast_wr: assert property (@(posedge clk) disable iff (!rstN)
    wTest && !softRst && chanSel[5:0] == CHAN_ALL |=>
    testCopy[0] == testCopy[5] && testCopy[4] == testCopy[1])
    else $error("broadcast write missed"); // [R6]
  a_local_read: assert property (@(posedge clk) disable iff (!rstN)
    chanSel[0] |-> localRd == testCopy[0])
    else $error("local read channel"); // [R8]
  a_global_idx: assert property (@(posedge clk) disable iff (!rstN)
    wClk && !softRst |=> clockCtrl == ($past(wr.data) & CLOCK_MASK))
    else $error("global write gated"); // [R9]
  a_oe_read: assert property (@(posedge clk) disable iff (!rstN)
    !dataOeN |-> isRead && phase == DATA)
    else $error("drive without read"); // [R15]
  a_open_zero: assert property (@(posedge clk) disable iff (!rstN)
    chanSel[7:6] == 2'b00) else $error("open bits set"); // [R18]
  // frame opening: select seen, then instruction counting from zero
  sequence sFrameOpen;
    csAssert && phase == IDLE;
  endsequence
  sequence sInstrLoaded;
    phase == INSTR && bitCnt == 5'd0;
  endsequence
  a_frame_start: assert property (@(posedge clk) disable iff (!rstN) // [R15]
    sFrameOpen |=> sInstrLoaded)
    else $error("frame start missed");
  a_frame_end: assert property (@(posedge clk) disable iff (!rstN) // [R15]
    csRelease |=> phase == IDLE && dataOeN)
    else $error("frame not closed");
  a_instr_addr: assert property (@(posedge clk) disable iff (!rstN) // [R13]
    instrDone |=> phase == DATA && curAddr[15:13] == 3'b000)
    else $error("instruction not taken");
  // streaming step: a completed byte moves the address by one
  sequence sByteMsb;
    wordDone && !csRelease && !lsbFirst;
  endsequence
  a_stream_step: assert property (@(posedge clk) disable iff (!rstN) // [R17]
    sByteMsb |=> curAddr == $past(curAddr) - 16'd1)
    else $error("stream address step");
  a_soft_locals: assert property (@(posedge clk) disable iff (!rstN) // [R12]
    softRst |=> testCopy[0] == TEST_RESET && testCopy[5] == TEST_RESET)
    else $error("soft reset locals");
  sequence sPowerWrite;
    wPow && !softRst;
  endsequence
  a_power_write: assert property (@(posedge clk) disable iff (!rstN) // [R9]
    sPowerWrite |=> powerMode == ($past(wr.data) & POWER_MASK))
    else $error("power write lost");
endmodule
`default_nettype wire

// ===== src/sync_3ff.sv
`default_nettype none
module sync_3ff (
  input wire logic clk, // core clock
  input wire logic rstN, // synced reset
  input wire logic pin, // async input
  input wire logic resetVal, // idle level of pin
  output logic level, // filtered level
  output logic rise, // one-cycle pulse
  output logic fall // one-cycle pulse
);
  logic s1, s2, s3;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin ^ resetVal;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
  // levels are stored relative to idle so reset is constant
  assign rise = (s2 == s3) && s3 && !level;
  assign fall = (s2 == s3) && !s3 && level;
endmodule
`default_nettype wire
